// ### dcd_pkg.sv
// command decoder package: widths, field positions, burst counts, enums
// assumes a standard dram command pin set sampled on the link clock
package dcd_pkg;

	localparam int DCD_ADDR_W = 16;
	localparam int DCD_BANK_W = 3;
	localparam int DCD_BANKS = 8;
	localparam int DCD_MR_COUNT = 4;
	localparam int DCD_MR_SEL_W = 2;

	// address bit positions that modify commands
	localparam int DCD_A10_POS = 10;
	localparam int DCD_A12_POS = 12;

	// burst-length field of mode register 0
	localparam int DCD_MR0_BL_LSB = 0;
	localparam logic [1:0] DCD_BL_FIXED8 = 2'h0;
	localparam logic [1:0] DCD_BL_OTF = 2'h1;
	localparam logic [1:0] DCD_BL_FIXED4 = 2'h2;
	localparam logic [DCD_ADDR_W-1:0] DCD_MR_RESET = 16'h0000;

	// burst occupancy in link clock cycles (two beats per cycle)
	localparam logic [3:0] DCD_BURST_CK_BL8 = 4'h4;
	localparam logic [3:0] DCD_BURST_CK_BC4 = 4'h2;
	localparam logic [3:0] DCD_BURST_MAX = 4'hf;

	// synchroniser depth for signals entering the core clock
	localparam int DCD_SYNC_STAGES = 3;
	localparam int DCD_SYNC_W = 7;

	// indices into the synchronised vector
	localparam int DCD_SY_TOG = 0;
	localparam int DCD_SY_CKE = 1;
	localparam int DCD_SY_BUSY = 2;
	localparam int DCD_SY_PWR = 3;

	typedef enum logic [3:0] {
		DCD_CMD_NONE = 4'h0,
		DCD_CMD_MRS = 4'h1,
		DCD_CMD_REF = 4'h2,
		DCD_CMD_PRE = 4'h3,
		DCD_CMD_ACT = 4'h4,
		DCD_CMD_WR = 4'h5,
		DCD_CMD_RD = 4'h6,
		DCD_CMD_ZQ = 4'h7,
		DCD_CMD_SRE = 4'h8,
		DCD_CMD_SRX = 4'h9,
		DCD_CMD_PDE = 4'ha,
		DCD_CMD_PDX = 4'hb
	} dcd_cmd_t;

	typedef enum logic [3:0] {
		DCD_ST_ACTIVE = 4'h1,
		DCD_ST_PPD = 4'h2,
		DCD_ST_APD = 4'h4,
		DCD_ST_SREF = 4'h8
	} dcd_pwr_t;

endpackage : dcd_pkg

// ### dcd_mode_regs.sv
// four mode registers written by the command decoder, registered read
// assumes write and read both run on the link clock
`timescale 1ns/1ps
`default_nettype none

module dcd_mode_regs
	import dcd_pkg::*;
(
	input wire logic ck,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [DCD_MR_SEL_W-1:0] wr_sel,
	input wire logic [DCD_ADDR_W-1:0] wr_data,
	input wire logic [DCD_MR_SEL_W-1:0] rd_sel,
	output logic [DCD_ADDR_W-1:0] rd_data
);

	logic [DCD_ADDR_W-1:0] regs [DCD_MR_COUNT];

	always_ff @(posedge ck or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DCD_MR_COUNT; i++) begin
				regs[i] <= DCD_MR_RESET;
			end
		end else if (wr_en) begin
			regs[wr_sel] <= wr_data;
		end
	end

	always_ff @(posedge ck or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= DCD_MR_RESET;
		end else begin
			rd_data <= regs[rd_sel];
		end
	end

endmodule : dcd_mode_regs
`default_nettype wire

// ### dcd_cmd_cke.sv
// command decode and clock-enable power state logic of the dram
// assumes the controller drives pins synchronous to ck; core side runs on clock
`timescale 1ns/1ps
`default_nettype none

module dcd_cmd_cke
	import dcd_pkg::*;
#(
	parameter int ADDR_W = DCD_ADDR_W
)(
	input wire logic clock,
	input wire logic nrst,
	input wire logic ck,
	input wire logic dram_reset_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [DCD_BANK_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic odt,
	output logic cmd_valid,
	output logic [3:0] cmd_code,
	output logic [DCD_BANK_W-1:0] cmd_bank,
	output logic [ADDR_W-1:0] cmd_addr,
	output logic cmd_auto_pre,
	output logic cmd_chop,
	output logic cmd_all_banks,
	output logic cmd_zq_long,
	output logic cmd_zq_init,
	output logic [3:0] pwr_state,
	output logic burst_busy,
	output logic in_self_refresh
);

	// base decode of the four command pins; nop and deselect both give none
	function automatic dcd_cmd_t dcd_decode(input logic [3:0] pins);
		dcd_cmd_t c;
		c = DCD_CMD_NONE;
		case (pins)
			4'h0: c = DCD_CMD_MRS;
			4'h1: c = DCD_CMD_REF;
			4'h2: c = DCD_CMD_PRE;
			4'h3: c = DCD_CMD_ACT;
			4'h4: c = DCD_CMD_WR;
			4'h5: c = DCD_CMD_RD;
			4'h6: c = DCD_CMD_ZQ;
			default: c = DCD_CMD_NONE;
		endcase
		return c;
	endfunction : dcd_decode

	// ---------------- link domain (ck) ----------------

	wire logic link_rst_n = nrst & dram_reset_n;

	// odt is deliberately left out of every decode term
	wire logic odt_unused = odt;

	dcd_pwr_t state;
	dcd_pwr_t next_state;
	logic cke_prev;
	logic [DCD_BANKS-1:0] bank_open;
	logic [DCD_BANKS-1:0] next_bank_open;
	logic [3:0] burst_left;
	logic [3:0] next_burst_left;
	logic zq_seen;
	logic [ADDR_W-1:0] mr0;

	logic ev_toggle;
	dcd_cmd_t ev_code;
	logic [DCD_BANK_W-1:0] ev_bank;
	logic [ADDR_W-1:0] ev_addr;
	logic ev_ap;
	logic ev_chop;
	logic ev_all;
	logic ev_zq_long;
	logic ev_zq_init;
	dcd_cmd_t next_ev;

	// cs low plus ras/cas/we; cs high forces the nop code
	wire logic [3:0] pin_code = {cs_n, ras_n, cas_n, we_n};
	wire dcd_cmd_t base_cmd = cs_n ? DCD_CMD_NONE : dcd_decode(pin_code);
	// nop and deselect share one code
	wire logic is_nop = (base_cmd == DCD_CMD_NONE);
	wire logic a10 = addr[DCD_A10_POS];
	wire logic a12 = addr[DCD_A12_POS];
	wire logic any_open = |bank_open;
	wire logic bursting = (burst_left != 4'h0);
	// idle means banks closed and no burst running
	wire logic all_idle = ~any_open & ~bursting;
	wire logic cke_fall = cke_prev & ~cke;
	wire logic cke_rise = ~cke_prev & cke;
	wire logic cke_hold_hi = cke_prev & cke;

	// burst length from the mode register 0 field or from a12
	wire logic [1:0] bl_mode = mr0[DCD_MR0_BL_LSB +: 2];
	wire logic chop = (bl_mode == DCD_BL_OTF) ? ~a12 : (bl_mode == DCD_BL_FIXED4);
	wire logic [3:0] burst_len = chop ? DCD_BURST_CK_BC4 : DCD_BURST_CK_BL8;

	// action chosen from prior state, cke history and the present command
	always_comb begin
		next_state = state;
		next_ev = DCD_CMD_NONE;
		case (state)
			DCD_ST_ACTIVE: begin
				if (cke_fall) begin
					// refresh with cke falling enters self-refresh only when all banks are closed and no burst is running
					if (base_cmd == DCD_CMD_REF && all_idle) begin
						next_state = DCD_ST_SREF;
						next_ev = DCD_CMD_SRE;
					end else if (is_nop) begin
						next_state = any_open ? DCD_ST_APD : DCD_ST_PPD;
						next_ev = DCD_CMD_PDE;
					end
				end else if (cke_hold_hi) begin
					// ordinary command with cke high on both edges
					next_ev = base_cmd;
				end
			end
			DCD_ST_PPD, DCD_ST_APD, DCD_ST_SREF: begin
				// cke low on both edges keeps the state
				// exit with any command but nop/des is not legal and is ignored
				// a refresh code is never acted on in these states
				if (cke_rise && is_nop) begin
					next_state = DCD_ST_ACTIVE;
					next_ev = (state == DCD_ST_SREF) ? DCD_CMD_SRX : DCD_CMD_PDX;
				end
			end
			default: begin
				next_state = DCD_ST_ACTIVE;
			end
		endcase
	end

	wire logic do_act = (next_ev == DCD_CMD_ACT);
	wire logic do_pre = (next_ev == DCD_CMD_PRE);
	wire logic do_rw = (next_ev == DCD_CMD_RD) || (next_ev == DCD_CMD_WR);
	wire logic do_mrs = (next_ev == DCD_CMD_MRS) && (ba[DCD_BANK_W-1] == 1'b0);
	wire logic do_zql = (next_ev == DCD_CMD_ZQ) && a10;

	// bank open bits; auto precharge is booked at issue as a simplification
	always_comb begin
		next_bank_open = bank_open;
		if (do_act) begin
			next_bank_open[ba] = 1'b1;
		end else if (do_pre && a10) begin
			next_bank_open = '0;
		end else if (do_pre) begin
			next_bank_open[ba] = 1'b0;
		end else if (do_rw && a10) begin
			// auto precharge closes the accessed bank
			next_bank_open[ba] = 1'b0;
		end
	end

	// a new burst only adds to the remaining count, never cuts it
	wire logic [4:0] burst_sum = {1'b0, burst_left} - {4'h0, bursting} + (do_rw ? {1'b0, burst_len} : 5'h00);
	always_comb begin
		if (burst_sum > {1'b0, DCD_BURST_MAX}) begin
			next_burst_left = DCD_BURST_MAX;
		end else begin
			next_burst_left = burst_sum[3:0];
		end
	end

	always_ff @(posedge ck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state <= DCD_ST_ACTIVE;
			cke_prev <= 1'b0;
			bank_open <= '0;
			burst_left <= 4'h0;
		end else begin
			state <= next_state;
			cke_prev <= cke;
			bank_open <= next_bank_open;
			burst_left <= next_burst_left;
		end
	end

	// first long calibration since reset is the initial one
	always_ff @(posedge ck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			zq_seen <= 1'b0;
		end else if (do_zql) begin
			zq_seen <= 1'b1;
		end
	end

	// bank inputs pick the mode register, address carries the opcode
	dcd_mode_regs u_mode_regs (
		.ck(ck),
		.rst_n(link_rst_n),
		.wr_en(do_mrs),
		.wr_sel(ba[DCD_MR_SEL_W-1:0]),
		.wr_data(addr),
		.rd_sel({DCD_MR_SEL_W{1'b0}}),
		.rd_data(mr0)
	);

	// the toggle sees only the core reset: a pin reset must not fake an event
	wire logic ev_fire = (next_ev != DCD_CMD_NONE);
	always_ff @(posedge ck or negedge nrst) begin
		if (!nrst) begin
			ev_toggle <= 1'b0;
		end else if (ev_fire) begin
			ev_toggle <= ~ev_toggle;
		end
	end

	// event word held until the next event so the core can copy it
	// bank and row/column address pass through unchanged
	always_ff @(posedge ck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ev_code <= DCD_CMD_NONE;
			ev_bank <= '0;
			ev_addr <= '0;
			ev_ap <= 1'b0;
			ev_chop <= 1'b0;
			ev_all <= 1'b0;
			ev_zq_long <= 1'b0;
			ev_zq_init <= 1'b0;
		end else if (ev_fire) begin
			ev_code <= next_ev;
			ev_bank <= ba;
			ev_addr <= addr;
			ev_ap <= do_rw & a10;
			ev_chop <= do_rw & chop;
			ev_all <= do_pre & a10;
			ev_zq_long <= (next_ev == DCD_CMD_ZQ) & a10;
			ev_zq_init <= do_zql & ~zq_seen;
		end
	end

	// ---------------- core domain (clock) ----------------

	// cke goes straight to the core so self-refresh exit does not wait for ck
	wire logic [DCD_SYNC_W-1:0] sync_in = {state, bursting, cke, ev_toggle};
	logic [DCD_SYNC_W-1:0] sync_s1;
	logic [DCD_SYNC_W-1:0] sync_s2;
	logic [DCD_SYNC_W-1:0] sync_s3;
	logic [DCD_SYNC_W-1:0] filt;
	logic tog_seen;
	// stages start at the reset power state, so no false step follows reset
	localparam logic [DCD_SYNC_W-1:0] SYNC_RST = DCD_SYNC_W'(DCD_ST_ACTIVE) << DCD_SY_PWR;

	genvar g;
	generate
		for (g = 0; g < DCD_SYNC_W; g++) begin : g_sync
			// a change counts only once the second and third stage agree
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					sync_s1[g] <= SYNC_RST[g];
					sync_s2[g] <= SYNC_RST[g];
					sync_s3[g] <= SYNC_RST[g];
					filt[g] <= SYNC_RST[g];
				end else begin
					sync_s1[g] <= sync_in[g];
					sync_s2[g] <= sync_s1[g];
					sync_s3[g] <= sync_s2[g];
					if (sync_s2[g] == sync_s3[g]) begin
						filt[g] <= sync_s3[g];
					end
				end
			end
		end
	endgenerate

	wire logic new_event = (filt[DCD_SY_TOG] != tog_seen);
	wire logic sref_flag = filt[DCD_SY_PWR + 3];
	wire logic cke_core = filt[DCD_SY_CKE];

	// copy of the held word; it is stable while the toggle is in flight
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tog_seen <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_code <= DCD_CMD_NONE;
			cmd_bank <= '0;
			cmd_addr <= '0;
			cmd_auto_pre <= 1'b0;
			cmd_chop <= 1'b0;
			cmd_all_banks <= 1'b0;
			cmd_zq_long <= 1'b0;
			cmd_zq_init <= 1'b0;
		end else begin
			tog_seen <= filt[DCD_SY_TOG];
			cmd_valid <= new_event;
			if (new_event) begin
				cmd_code <= ev_code;
				cmd_bank <= ev_bank;
				cmd_addr <= ev_addr;
				cmd_auto_pre <= ev_ap;
				cmd_chop <= ev_chop;
				cmd_all_banks <= ev_all;
				cmd_zq_long <= ev_zq_long;
				cmd_zq_init <= ev_zq_init;
			end
		end
	end

	// self-refresh ends in the core as soon as cke is seen high
	// pwr_state bits cross one by one; in silicon they may disagree for a clock
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pwr_state <= DCD_ST_ACTIVE;
			burst_busy <= 1'b0;
			in_self_refresh <= 1'b0;
		end else begin
			pwr_state <= filt[DCD_SY_PWR +: 4];
			burst_busy <= filt[DCD_SY_BUSY];
			in_self_refresh <= sref_flag & ~cke_core;
		end
	end

endmodule : dcd_cmd_cke
`default_nettype wire

// ### dcd_cmd_cke_assertions.sv
// checker of the decoder's core-side event outputs
// assumes a bind onto dcd_cmd_cke, core clock domain only
`timescale 1ns/1ps
`default_nettype none

module dcd_cmd_cke_assertions (
	input wire logic clock,
	input wire logic nrst,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_code,
	input wire logic cmd_auto_pre,
	input wire logic cmd_chop,
	input wire logic cmd_all_banks,
	input wire logic cmd_zq_long,
	input wire logic cmd_zq_init,
	input wire logic [3:0] pwr_state
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	wire logic rw = cmd_code == 4'h5 || cmd_code == 4'h6;
	sequence s_quiet;
		##1 !cmd_valid;
	endsequence
	chk_valid_pulse: assert property (cmd_valid |-> s_quiet)
		else $error("event pulse too long");
	chk_code_hold: assert property (!$stable(cmd_code) |-> cmd_valid)
		else $error("code changed without event");
	chk_no_idle_event: assert property (cmd_valid |-> cmd_code != 4'h0)
		else $error("event without command");
	chk_auto_pre_rw: assert property (cmd_valid && cmd_auto_pre |-> rw)
		else $error("auto precharge on wrong command");
	chk_chop_rw: assert property (cmd_valid && cmd_chop |-> rw)
		else $error("chop on wrong command");
	chk_all_banks_pre: assert property (cmd_valid && cmd_all_banks |-> cmd_code == 4'h3)
		else $error("all banks on wrong command");
	chk_zq_long_kind: assert property (cmd_valid && cmd_zq_long |-> cmd_code == 4'h7)
		else $error("long calibration on wrong command");
	chk_zq_init_long: assert property (cmd_zq_init |-> cmd_zq_long)
		else $error("initial calibration not long");
	chk_pwr_onehot: assert property ($onehot(pwr_state))
		else $error("power state not one-hot");
endmodule : dcd_cmd_cke_assertions

`default_nettype wire

// ### dcd_ctrl_model.sv
// controller-side model: link clock, clock enable and command pins
// assumes the bench issues one word per link edge through drive
`timescale 1ns/1ps
`default_nettype none

module dcd_ctrl_model
	import dcd_pkg::*;
(
	output logic ck,
	output logic dram_reset_n,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [DCD_BANK_W-1:0] ba,
	output logic [DCD_ADDR_W-1:0] addr,
	output logic odt
);
	initial begin
		dram_reset_n = 1'b1;
		cke = 1'b0;
		{cs_n, ras_n, cas_n, we_n} = 4'h7;
		ba = '0;
		addr = '0;
		odt = 1'b0;
		ck = 1'b0;
		#7;
		forever begin
			ck = ~ck;
			#80;
		end
	end
	// termination toggles to prove it is ignored
	always @(posedge ck)
		odt <= ~odt;
	// reset pin pulsed low for one link period
	task automatic pin_reset;
		@(posedge ck);
		dram_reset_n <= 1'b0;
		@(posedge ck);
		dram_reset_n <= 1'b1;
	endtask : pin_reset
	// each word held a whole link period, levels defined
	task automatic drive(input logic k, input logic [3:0] c, input logic [2:0] b,
		input logic [15:0] a);
		@(posedge ck);
		cke <= k;
		{cs_n, ras_n, cas_n, we_n} <= c;
		ba <= b;
		addr <= a;
	endtask : drive
endmodule : dcd_ctrl_model

`default_nettype wire

// ### dcd_cmd_cke_tb_top.sv
// bench top: core clock, controller model, decoder and checker
// assumes the package and design files are compiled first
`timescale 1ns/1ps
`default_nettype none

module dcd_cmd_cke_tb_top;
	localparam logic [3:0] MRS = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
	localparam logic [3:0] WRC = 4'h4, RDC = 4'h5, ZQC = 4'h6, NOP = 4'h7, DES = 4'hd;
	logic clock, nrst, ck, dram_reset_n, cke, cs_n, ras_n, cas_n, we_n, odt;
	logic cmd_valid, cmd_auto_pre, cmd_chop, cmd_all_banks, cmd_zq_long, cmd_zq_init;
	logic burst_busy, in_self_refresh;
	logic [2:0] ba, cmd_bank;
	logic [15:0] addr, cmd_addr;
	logic [3:0] cmd_code, pwr_state;
	int fails = 0;
	int checks_done = 0;
	int nev = 0;
	int cyc = 0;

	dcd_ctrl_model i_ctrl (.ck, .dram_reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
		.ba, .addr, .odt);
	dcd_cmd_cke i_dut (.clock, .nrst, .ck, .dram_reset_n, .cke, .cs_n, .ras_n, .cas_n,
		.we_n, .ba, .addr, .odt, .cmd_valid, .cmd_code, .cmd_bank, .cmd_addr,
		.cmd_auto_pre, .cmd_chop, .cmd_all_banks, .cmd_zq_long, .cmd_zq_init,
		.pwr_state, .burst_busy, .in_self_refresh);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(negedge clock) begin
		cyc++;
		if (cmd_valid === 1'b1)
			nev++;
		if (cyc == 3000) begin
			fails++;
			give_verdict();
		end
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			fails++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk

	// flags ef are {auto_pre, chop, all_banks, zq_long, zq_init}
	task automatic step(input logic k, input logic [3:0] c, input logic [2:0] b,
		input logic [15:0] a, input logic [3:0] ec, input logic [4:0] ef,
		input logic [3:0] ep);
		int n;
		i_ctrl.drive(k, c, b, a);
		i_ctrl.drive(k, NOP, 3'h0, 16'h0000);
		n = 0;
		while (cmd_valid !== 1'b1 && n < 30) begin
			@(negedge clock);
			n++;
		end
		chk(n < 30, "no event");
		chk(cmd_code === ec, "command code");
		if (ec == 4'h5 || ec == 4'h6)
			chk(burst_busy === 1'b1, "burst not busy");
		if (ec < 4'h8) begin
			chk({cmd_bank, cmd_addr} === {b, a}, "bank or address");
			chk({cmd_auto_pre, cmd_chop, cmd_all_banks, cmd_zq_long, cmd_zq_init} === ef,
				"modifier flags");
		end
		repeat (4) @(negedge clock);
		chk(pwr_state === ep, "power state");
		chk(in_self_refresh === (ep == 4'h8), "self-refresh flag");
	endtask : step

	// repeated words that must raise no event
	task automatic quiet(input logic k, input logic [3:0] c);
		int e;
		e = nev;
		repeat (3) i_ctrl.drive(k, c, 3'h5, 16'hffff);
		repeat (16) @(negedge clock);
		chk(nev == e, "ignored word made an event");
		chk(burst_busy === 1'b0, "burst still busy");
	endtask : quiet

	task automatic t_cmds;
		step(1'b1, REF, 3'h0, 16'h0000, 4'h2, 5'h00, 4'h1);
		step(1'b1, MRS, 3'h0, 16'h0001, 4'h1, 5'h00, 4'h1);
		step(1'b1, ACT, 3'h2, 16'h1234, 4'h4, 5'h00, 4'h1);
		step(1'b1, WRC, 3'h2, 16'h0408, 4'h5, 5'h18, 4'h1);
		step(1'b1, RDC, 3'h1, 16'h1010, 4'h6, 5'h00, 4'h1);
		step(1'b1, PRE, 3'h6, 16'h0400, 4'h3, 5'h04, 4'h1);
		step(1'b1, ZQC, 3'h0, 16'h0400, 4'h7, 5'h03, 4'h1);
		step(1'b1, ZQC, 3'h0, 16'h0400, 4'h7, 5'h02, 4'h1);
		step(1'b1, ZQC, 3'h0, 16'h0000, 4'h7, 5'h00, 4'h1);
		quiet(1'b1, DES);
		$display("test commands done");
	endtask : t_cmds

	task automatic t_power;
		step(1'b0, NOP, 3'h0, 16'h0000, 4'ha, 5'h00, 4'h2);
		quiet(1'b0, ACT);
		quiet(1'b0, REF);
		step(1'b1, NOP, 3'h0, 16'h0000, 4'hb, 5'h00, 4'h1);
		step(1'b1, ACT, 3'h3, 16'h0042, 4'h4, 5'h00, 4'h1);
		step(1'b0, DES, 3'h0, 16'h0000, 4'ha, 5'h00, 4'h4);
		step(1'b1, DES, 3'h0, 16'h0000, 4'hb, 5'h00, 4'h1);
		step(1'b1, PRE, 3'h0, 16'h0400, 4'h3, 5'h04, 4'h1);
		step(1'b0, REF, 3'h0, 16'h0000, 4'h8, 5'h00, 4'h8);
		quiet(1'b0, WRC);
		step(1'b1, NOP, 3'h0, 16'h0000, 4'h9, 5'h00, 4'h1);
		$display("test power states done");
	endtask : t_power

	// fixed chop mode, mrs with bank bit 2 set, then a pin reset mid-run
	task automatic t_modes;
		int e;
		step(1'b1, MRS, 3'h0, 16'h0002, 4'h1, 5'h00, 4'h1);
		step(1'b1, RDC, 3'h4, 16'h1000, 4'h6, 5'h08, 4'h1);
		step(1'b1, MRS, 3'h4, 16'h0000, 4'h1, 5'h00, 4'h1);
		step(1'b1, WRC, 3'h5, 16'h0000, 4'h5, 5'h08, 4'h1);
		step(1'b0, NOP, 3'h0, 16'h0000, 4'ha, 5'h00, 4'h2);
		e = nev;
		i_ctrl.pin_reset();
		repeat (12) @(negedge clock);
		chk(pwr_state === 4'h1 && burst_busy === 1'b0 && nev == e, "pin reset");
		i_ctrl.drive(1'b1, NOP, 3'h0, 16'h0000);
		step(1'b1, ZQC, 3'h0, 16'h0400, 4'h7, 5'h03, 4'h1);
		step(1'b1, WRC, 3'h1, 16'h0000, 4'h5, 5'h00, 4'h1);
		$display("test modes and pin reset done");
	endtask : t_modes

	initial begin
		nrst = 1'b0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		chk(pwr_state === 4'h1 && cmd_code === 4'h0, "reset values");
		i_ctrl.drive(1'b1, NOP, 3'h0, 16'h0000);
		t_cmds();
		t_power();
		t_modes();
		give_verdict();
	end
endmodule : dcd_cmd_cke_tb_top

bind dcd_cmd_cke dcd_cmd_cke_assertions i_chk (.clock, .nrst, .cmd_valid, .cmd_code,
	.cmd_auto_pre, .cmd_chop, .cmd_all_banks, .cmd_zq_long, .cmd_zq_init, .pwr_state);

`default_nettype wire
